// >>> verif/ofp_downstream_model.sv
`timescale 1ns/1ns
`default_nettype none
// downstream framer: picks the interface width and tallies accepted marks
module ofp_downstream_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // wanted width and the generator's pulses
    input wire logic mode_req,
    input wire logic [1:0] pulse,
    // width select toward the generator, marks taken
    output logic width_sel = 1'b1,
    output int marks
);
    // width moves only on an edge so the generator sees a clean level
    always @(posedge clk) begin
        width_sel <= mode_req;
    end
    // lane 2 means nothing in stm-4, so it is not counted there
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            marks <= 0;
        end else begin
            marks <= marks + int'(pulse[0]) + int'(pulse[1] & width_sel);
        end
    end
endmodule : ofp_downstream_model
`default_nettype wire

// >>> verif/ofp_frame_pulse_gen_props.sv
`timescale 1ns/1ns
`default_nettype none
module ofp_frame_pulse_gen_props
    import ofp_pkg::*;
(
    // clock and reset
    input wire logic CLK,
    input wire logic RST,
    // register bus
    input wire logic [5:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [31:0] AVS_READDATA,
    input wire logic AVS_WAITREQUEST,
    // mode and frame pulses
    input wire logic OUTGOING_INTERFACE_WIDTH_SELECT,
    input wire logic [1:0] INCOMING_FRAME_J1_PULSE,
    input wire logic [1:0] OUTGOING_COMPOSITE_FRAME_PULSE
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    ////////////////////////////////////////////////////////////////////////////
    // helper logic
    logic [11:0] ctrl_reg; // shadow of the control word
    int since_rst; // cycles since reset release, saturating
    logic [1:0] pls; // short alias of the pulse outputs
    logic [1:0] inc; // short alias of the incoming pulses
    logic wide; // stm-1 mode
    logic done; // read answered this cycle
    assign pls = OUTGOING_COMPOSITE_FRAME_PULSE;
    assign inc = INCOMING_FRAME_J1_PULSE;
    assign wide = OUTGOING_INTERFACE_WIDTH_SELECT;
    assign done = AVS_READ && !AVS_WAITREQUEST;
    // shadow follows writes at the edge where they are accepted
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ctrl_reg <= 12'h000;
        end else if (AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == REG_CTRL) begin
            ctrl_reg <= AVS_WRITEDATA[11:0];
        end
    end
    // saturates so long runs cannot wrap back onto the c1 cycle
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            since_rst <= 0;
        end else if (since_rst < 1000) begin
            since_rst <= since_rst + 1;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // assertions
    wait_one_cycle_a: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
        else $error("waitrequest low longer than one cycle");
    wait_answer_a: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
        else $error("bus request not answered in one cycle");
    ctrl_readback_a: assert property (done && AVS_ADDRESS == REG_CTRL |->
        AVS_READDATA == {20'h0, ctrl_reg}) else $error("control read mismatch");
    unmapped_zero_a: assert property (done && AVS_ADDRESS >= 6'h28 |-> AVS_READDATA == 32'h0)
        else $error("unmapped read not zero");
    mode_status_a: assert property (done && AVS_ADDRESS == REG_STATUS |->
        AVS_READDATA[16] == wide) else $error("status width bit wrong");
    c1_stm1_a: assert property (since_rst == 7 && wide |-> pls == 2'b11)
        else $error("stm-1 c1 pulse missing");
    // stm-4 starts one clock late: the width flop leaves its reset value first
    c1_stm4_a: assert property (since_rst == 26 && !wide |-> pls[0])
        else $error("stm-4 c1 pulse missing");
    // two delay flops, then the output flop
    bypass_copy_a: assert property (inc[0] && (!ctrl_reg[0] || ctrl_reg[4]) |->
        ##3 pls[0]) else $error("bypass copy missing on lane 1");
    bypass_lane2_a: assert property (inc[1] && wide && (!ctrl_reg[1] || ctrl_reg[5])
        |-> ##3 pls[1]) else $error("bypass copy missing on lane 2");
    pulse_single_a: assert property (wide && $past(wide) && pls[0] |=> !pls[0])
        else $error("lane 1 pulse longer than one cycle");
    // the outputs follow the width select two clocks late
    lane2_quiet_a: assert property (!wide && !$past(wide, 2) |-> !pls[1])
        else $error("lane 2 active in stm-4");
    reset_quiet_a: assert property (disable iff (1'b0) RST && $past(RST) |->
        AVS_WAITREQUEST && pls == 2'b00) else $error("outputs active in reset");
    // main scenarios
    cover property (inc[0] ##3 pls[0]);
    cover property (since_rst == 26 && !wide && pls[0]);
    cover property (AVS_WRITE && !AVS_WAITREQUEST);
endmodule : ofp_frame_pulse_gen_props
bind ofp_frame_pulse_gen ofp_frame_pulse_gen_props chk_u (.CLK, .RST, .AVS_ADDRESS,
    .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA, .AVS_READDATA, .AVS_WAITREQUEST,
    .OUTGOING_INTERFACE_WIDTH_SELECT, .INCOMING_FRAME_J1_PULSE,
    .OUTGOING_COMPOSITE_FRAME_PULSE);
`default_nettype wire

// >>> verif/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import ofp_pkg::*;
    ////////////////////////////////////////////////////////////////////////////
    // signals and state
    logic CLK = 1'b0;
    logic RST = 1'b0;
    logic [5:0] addr = 6'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic wait_req;
    logic width;
    logic mode_req = 1'b1;
    logic [1:0] inc = 2'h0;
    logic [1:0] pulse;
    logic [9:0] ptr [4];
    int marks;
    int fails = 0;
    int samples_checked = 0;
    int seed = 32'hff0dd82b;
    int n = 0; // cycles since reset release
    int t_in = -1; // cycle of the injected incoming pulse
    int q[2][$]; // seen pulse cycles per lane
    int e[2][$]; // expected pulse cycles per lane
    always #(CLK_PERIOD_NS / 2) CLK = ~CLK;
    ofp_frame_pulse_gen dut_u (.CLK(CLK), .RST(RST), .AVS_ADDRESS(addr), .AVS_READ(rd),
        .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata),
        .AVS_WAITREQUEST(wait_req), .OUTGOING_INTERFACE_WIDTH_SELECT(width),
        .INCOMING_FRAME_J1_PULSE(inc), .OUTGOING_COMPOSITE_FRAME_PULSE(pulse));
    ofp_downstream_model far_u (.clk(CLK), .rst(RST), .mode_req(mode_req), .pulse(pulse),
        .width_sel(width), .marks(marks));
    ////////////////////////////////////////////////////////////////////////////
    // pulse recorder and incoming pulse driver, both keyed to n
    always @(posedge CLK) begin
        if (RST) begin
            n <= 0;
        end else begin
            for (int l = 0; l < 2; l++) if (pulse[l] === 1'b1) q[l].push_back(n);
            n <= n + 1;
        end
        inc <= {2{n + 1 == t_in}};
    end
    ////////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic void chk(string what, logic [31:0] exp, logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
        end
    endfunction : chk
    // byte position of j1 for pointer p; in stm-4 the stream owns slot k
    function automatic int j1_pos(int p, int k, bit stm4);
        int row;
        int col;
        row = (3 + p / 87) % 9;
        col = 9 + 3 * (p % 87);
        return stm4 ? row * 1080 + 4 * col + k : row * 270 + col;
    endfunction : j1_pos
    // one avalon access; the request stands until waitrequest is seen low
    task automatic bus(input bit w, input logic [5:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        addr <= a;
        wr <= w;
        rd <= !w;
        wdata <= d;
        // a wait that never ends is left to the watchdog
        do begin
            @(posedge CLK);
        end while (wait_req !== 1'b0);
        r = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge CLK);
    endtask : bus
    // reset in the wanted mode, program, then compare the second frame
    task automatic run(input bit stm4, input logic [11:0] ctrl);
        int f;
        int w[$];
        logic [31:0] r;
        f = int'(FRAME_ROWS) * (stm4 ? int'(STM4_COLS) : int'(STM1_COLS));
        mode_req <= !stm4;
        repeat (3) @(posedge CLK);
        RST <= 1'b1;
        repeat (6) @(posedge CLK);
        RST <= 1'b0;
        q[0].delete();
        q[1].delete();
        t_in = f + 100 + int'($unsigned($random(seed)) % 500);
        bus(0, REG_CTRL, 32'h0, r);
        chk("ctrl after reset", CTRL_RESET, r);
        bus(1, REG_CTRL, {20'h0, ctrl}, r);
        for (int k = 0; k < 4; k++) begin
            bus(1, 6'(8 + 8 * k), {30'h0, ptr[k][9:8]}, r);
            bus(1, 6'(12 + 8 * k), {24'h0, ptr[k][7:0]}, r);
        end
        bus(0, REG_STATUS, 32'h0, r);
        chk("width status", {31'h0, !stm4}, {31'h0, r[16]});
        bus(0, 6'h3c, 32'h0, r);
        chk("unmapped read", 32'h0, r);
        bus(0, 6'h0c, 32'h0, r);
        chk("pointer lsb", {24'h0, ptr[0][7:0]}, r);
        // stm-4 starts one clock late: the width flop leaves its reset value first
        e[0] = {f + (stm4 ? 26 : 7)};
        e[1].delete();
        if (!stm4) e[1].push_back(f + 7);
        for (int k = 0; k < (stm4 ? 4 : 2); k++) begin
            int l = stm4 ? 0 : k;
            int j = j1_pos(ptr[k], k, stm4) + (stm4 ? 2 : 1);
            if (ctrl[k] && !ctrl[4 + k]) begin
                e[l].push_back(f + j % f);
                // v1 is three bytes of the same stream later
                if (ctrl[8 + k]) e[l].push_back(f + (j + (stm4 ? 12 : 3)) % f);
            end else if (!stm4 || k == 0) begin
                // two delay flops, then the output flop
                e[l].push_back(t_in + BYPASS_DELAY + 1);
            end
        end
        while (n < 2 * f) @(posedge CLK);
        for (int l = 0; l < 2; l++) begin
            w.delete();
            foreach (q[l][i]) if (q[l][i] >= f && q[l][i] < 2 * f) w.push_back(q[l][i]);
            w.sort();
            e[l].sort();
            chk("pulse count", e[l].size(), w.size());
            foreach (e[l][i]) begin
                if (i < w.size()) chk("pulse cycle", e[l][i], w[i]);
            end
        end
    endtask : run
    task automatic test_done;
        $display("checks %0d, mismatches %0d, marks %0d", samples_checked, fails, marks);
        if (fails == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : test_done
    ////////////////////////////////////////////////////////////////////////////
    // main sequence: corner pointers first, then random configurations
    initial begin
        RST = 1'b1;
        repeat (6) @(posedge CLK);
        ptr = '{10'h000, 10'h30e, 10'h056, 10'h057};
        run(0, 12'h303);
        run(0, 12'h000);
        run(0, 12'h123);
        for (int i = 0; i < 3; i++) begin
            foreach (ptr[k]) ptr[k] = 10'($unsigned($random(seed)) % 783);
            run(0, 12'($random(seed)));
        end
        run(1, {4'($random(seed)), 8'h0f});
        run(1, 12'h0ff);
        test_done();
    end
    // hang guard, well past the expected run length
    initial begin
        #(100000 * CLK_PERIOD_NS);
        fails++;
        test_done();
    end
endmodule : testbench
`default_nettype wire

// >>> verilog/ofp_frame_pulse_gen.sv
// Our own choices: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - stm-1: pulse first c1 on own lane
// - stm-1: pulse also on each j1 byte
// - enabled, not bypassed: j1 from pointer registers
// - v1 enable: pulse third byte after j1
// - bypass: j1/v1 pulses delay incoming pulse; in stm-4 only stream 1's bypass does, for all four streams
// - stm-1: outputs change on clock rising edge
// - stm-4: pulse 1 marks first stm-4 c1
// - stm-4: pulse 1 marks every stm-1 j1
// - stm-4: each stm-1 uses own pointer pair
// - stm-4: pulse 1 changes on rising edge
// - stm-4: pulse 2 meaningless, held low
module ofp_frame_pulse_gen
    import ofp_pkg::*;
(
    // clock and reset
    input wire logic CLK,
    input wire logic RST,
    // avalon-mm register slave
    input wire logic [5:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    // interface mode and incoming frame pulses
    input wire logic OUTGOING_INTERFACE_WIDTH_SELECT,
    input wire logic [1:0] INCOMING_FRAME_J1_PULSE,
    // outgoing composite frame pulses, lane 1 and lane 2
    output logic [1:0] OUTGOING_COMPOSITE_FRAME_PULSE
);

    ////////////////////////////////////////////////////////////////////////////
    // declarations
    ofp_bus_state_t bus_state_reg;           // avalon handshake state
    logic wait_reg;                          // drives waitrequest
    logic [31:0] rdata_reg;                  // read data held for the answer cycle
    logic [31:0] ctrl_reg;                   // enables, bypass and v1 marking
    logic [9:0] ptr_reg [STREAMS];           // outgoing pointer per stm-1 stream
    logic mode_reg;                          // width select, 1 = stm-1 lanes
    logic [3:0] row_reg;                     // frame row counter
    logic [10:0] col_reg;                    // frame column counter
    logic [10:0] col_last;                   // last column for the current mode
    logic [3:0] j1_row [STREAMS];            // j1 row per stream
    logic [8:0] j1_col [STREAMS];            // j1 column per stream
    logic [3:0] tge;                         // tributary group enable per stream
    logic [3:0] byp;                         // tributary group bypass per stream
    logic [3:0] v1en;                        // first tributary mark enable per stream
    logic [3:0] bypassed;                    // bypass in effect per stream
    logic [1:0] sub;                         // stm-1 slot of the current stm-4 byte
    logic [8:0] sub_col;                     // column inside that stm-1
    logic c1_hit;                            // counter sits on the first c1
    logic [1:0] j1_hit;                      // counter sits on a j1, per lane
    logic [V1_TAP_STM4-1:0] j1_dly1_reg;     // lane 1 j1 history for v1 marking
    logic [V1_BYTES_AFTER_J1-1:0] j1_dly2_reg; // lane 2 j1 history for v1 marking
    logic [BYPASS_DELAY-1:0] in_dly_reg [2]; // incoming pulse delay lines
    logic [1:0] v1_hit;                      // v1 position reached, per lane
    logic [1:0] pulse_next;                  // next value of the outputs
    logic [1:0] pulse_reg;                   // output flops
    logic req;                               // a bus request is present
    logic [2:0] ptr_idx;                     // pointer register index from the address

    assign req = AVS_READ | AVS_WRITE;
    assign ptr_idx = 3'((AVS_ADDRESS - REG_PTR_BASE) >> 2);

    ////////////////////////////////////////////////////////////////////////////
    // control fields
    assign tge = ctrl_reg[CTRL_TGE_POS +: 4];
    assign byp = ctrl_reg[CTRL_BYP_POS +: 4];
    assign v1en = ctrl_reg[CTRL_V1_POS +: 4];
    assign bypassed = ~tge | byp;

    ////////////////////////////////////////////////////////////////////////////
    // avalon handshake: every access waits one cycle, answer in the second
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            bus_state_reg <= OFP_BUS_IDLE;
            wait_reg <= 1'b1;
        end else begin
            case (bus_state_reg)
                OFP_BUS_IDLE: begin
                    // request seen: drop waitrequest for one cycle
                    if (req) begin
                        bus_state_reg <= OFP_BUS_ANSWER;
                        wait_reg <= 1'b0;
                    end
                end
                OFP_BUS_ANSWER: begin
                    // master samples waitrequest low here and releases
                    bus_state_reg <= OFP_BUS_IDLE;
                    wait_reg <= 1'b1;
                end
                default: begin
                    bus_state_reg <= OFP_BUS_IDLE;
                    wait_reg <= 1'b1;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data: captured in the idle cycle so it stands during the answer
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            rdata_reg <= 32'h0000_0000;
        end else if (bus_state_reg == OFP_BUS_IDLE && AVS_READ) begin
            if (AVS_ADDRESS == REG_CTRL) begin
                rdata_reg <= ctrl_reg;
            end else if (AVS_ADDRESS == REG_STATUS) begin
                // live frame position, useful when aligning downstream logic
                rdata_reg <= 32'h0000_0000;
                rdata_reg[STAT_ROW_POS +: 4] <= row_reg;
                rdata_reg[STAT_COL_POS +: 11] <= col_reg;
                rdata_reg[STAT_MODE_POS] <= mode_reg;
            end else if (AVS_ADDRESS >= REG_PTR_BASE && AVS_ADDRESS <= REG_PTR_LAST
                         && AVS_ADDRESS[1:0] == 2'h0) begin
                // even index is msb (bits 9:8), odd index is lsb (bits 7:0)
                if (ptr_idx[0]) begin
                    rdata_reg <= {24'h00_0000, ptr_reg[ptr_idx[2:1]][7:0]};
                end else begin
                    rdata_reg <= {30'h0000_0000, ptr_reg[ptr_idx[2:1]][9:8]};
                end
            end else begin
                // unmapped addresses read as zero
                rdata_reg <= 32'h0000_0000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control register write, takes effect at the answer edge
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ctrl_reg <= CTRL_RESET;
        end else if (bus_state_reg == OFP_BUS_ANSWER && AVS_WRITE && AVS_ADDRESS == REG_CTRL) begin
            // only the twelve defined bits are kept
            ctrl_reg <= {20'h0_0000, AVS_WRITEDATA[11:0]};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pointer register pairs; software writes msb and lsb separately
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            for (int i = 0; i < STREAMS; i++) begin
                ptr_reg[i] <= PTR_RESET;
            end
        end else if (bus_state_reg == OFP_BUS_ANSWER && AVS_WRITE
                     && AVS_ADDRESS >= REG_PTR_BASE && AVS_ADDRESS <= REG_PTR_LAST
                     && AVS_ADDRESS[1:0] == 2'h0) begin
            if (ptr_idx[0]) begin
                ptr_reg[ptr_idx[2:1]][7:0] <= AVS_WRITEDATA[7:0];
            end else begin
                ptr_reg[ptr_idx[2:1]][9:8] <= AVS_WRITEDATA[1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pointer to j1 position, one locator per stm-1 stream
    for (genvar k = 0; k < STREAMS; k++) begin : g_loc
        ofp_j1_locator u_loc (
            .ptr(ptr_reg[k]),
            .j1_row(j1_row[k]),
            .j1_col(j1_col[k])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // interface width select; a change restarts frame timing
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            mode_reg <= 1'b1;
        end else begin
            mode_reg <= OUTGOING_INTERFACE_WIDTH_SELECT;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // frame position counter: one byte per clock on every lane
    assign col_last = mode_reg ? (STM1_COLS - 11'h001) : (STM4_COLS - 11'h001);

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            row_reg <= 4'h0;
            col_reg <= 11'h000;
        end else if (mode_reg != OUTGOING_INTERFACE_WIDTH_SELECT) begin
            // new geometry: start a fresh frame rather than run off the end
            row_reg <= 4'h0;
            col_reg <= 11'h000;
        end else if (col_reg >= col_last) begin
            col_reg <= 11'h000;
            row_reg <= (row_reg == FRAME_ROWS - 4'h1) ? 4'h0 : row_reg + 4'h1;
        end else begin
            col_reg <= col_reg + 11'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // position decode: stm-4 bytes interleave the four stm-1 streams
    always_comb begin
        sub = mode_reg ? 2'h0 : col_reg[1:0];
        sub_col = mode_reg ? col_reg[8:0] : col_reg[10:2];
        if (mode_reg) begin
            c1_hit = (row_reg == 4'h0) && (col_reg == STM1_C1_COL);
            // each lane uses its own stream's pointer
            j1_hit[0] = tge[0] && !byp[0] && row_reg == j1_row[0]
                        && col_reg[8:0] == j1_col[0];
            j1_hit[1] = tge[1] && !byp[1] && row_reg == j1_row[1]
                        && col_reg[8:0] == j1_col[1];
        end else begin
            c1_hit = (row_reg == 4'h0) && (col_reg == STM4_C1_COL);
            // the slot picks which stm-1 pointer pair applies
            j1_hit[0] = tge[sub] && !byp[sub] && row_reg == j1_row[sub]
                        && sub_col == j1_col[sub];
            j1_hit[1] = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // j1 history; v1 sits three bytes of the same stream after j1
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            j1_dly1_reg <= '0;
            j1_dly2_reg <= '0;
        end else begin
            j1_dly1_reg <= {j1_dly1_reg[V1_TAP_STM4-2:0], j1_hit[0]};
            j1_dly2_reg <= {j1_dly2_reg[V1_BYTES_AFTER_J1-2:0], j1_hit[1]};
        end
    end

    // in stm-4 three bytes of one stream span twelve clocks
    always_comb begin
        if (mode_reg) begin
            v1_hit[0] = v1en[0] && j1_dly1_reg[V1_BYTES_AFTER_J1-1];
            v1_hit[1] = v1en[1] && j1_dly2_reg[V1_BYTES_AFTER_J1-1];
        end else begin
            // the delayed j1 came from the stream of the current slot
            v1_hit[0] = v1en[sub] && j1_dly1_reg[V1_TAP_STM4-1];
            v1_hit[1] = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // incoming pulse delay lines used while bypass is in effect
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            in_dly_reg[0] <= '0;
            in_dly_reg[1] <= '0;
        end else begin
            for (int l = 0; l < 2; l++) begin
                in_dly_reg[l] <= {in_dly_reg[l][BYPASS_DELAY-2:0], INCOMING_FRAME_J1_PULSE[l]};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // combine c1, j1 and v1 marks per lane
    always_comb begin
        pulse_next = 2'h0;
        if (mode_reg) begin
            for (int l = 0; l < 2; l++) begin
                if (bypassed[l]) begin
                    // j1/v1 come from the incoming pulse; c1 stays local
                    pulse_next[l] = c1_hit || in_dly_reg[l][BYPASS_DELAY-1];
                end else begin
                    pulse_next[l] = c1_hit || j1_hit[l] || v1_hit[l];
                end
            end
        end else begin
            // the whole stm-4 follows stream 1's bypass setting
            if (bypassed[0]) begin
                pulse_next[0] = c1_hit || in_dly_reg[0][BYPASS_DELAY-1];
            end else begin
                pulse_next[0] = c1_hit || j1_hit[0] || v1_hit[0];
            end
            pulse_next[1] = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // output flops; each decoded position lasts one clock, but stm-4 marks in adjacent slots merge into one longer pulse
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            pulse_reg <= 2'h0;
        end else begin
            pulse_reg <= pulse_next;
        end
    end

    assign OUTGOING_COMPOSITE_FRAME_PULSE = pulse_reg;
    assign AVS_READDATA = rdata_reg;
    assign AVS_WAITREQUEST = wait_reg;

endmodule : ofp_frame_pulse_gen
`default_nettype wire

// >>> verilog/ofp_j1_locator.sv
`timescale 1ns/1ns
`default_nettype none
// turns an au pointer value into the row and column of j1 in one stm-1
module ofp_j1_locator
    import ofp_pkg::*;
(
    // pointer value from the msb/lsb register pair
    input wire logic [9:0] ptr,
    // j1 position inside the stm-1 frame
    output logic [3:0] j1_row,
    output logic [8:0] j1_col
);

    ////////////////////////////////////////////////////////////////////////////
    // locate j1: each pointer step is three bytes, 87 steps per row
    logic [3:0] step_row;   // whole rows past the pointer row
    logic [6:0] step_rem;   // steps left inside the row
    logic [4:0] raw_row;    // row before wrapping into the next frame

    always_comb begin
        step_row = 4'(ptr / PTR_PER_ROW);
        step_rem = 7'(ptr - 10'(10'(step_row) * PTR_PER_ROW));
        raw_row = 5'(PAYLOAD_ROW) + 5'(step_row);
        // payload past row 8 continues in rows 0-2 of the next frame
        if (raw_row >= 5'(FRAME_ROWS)) begin
            j1_row = 4'(raw_row - 5'(FRAME_ROWS));
        end else begin
            j1_row = raw_row[3:0];
        end
        j1_col = PAYLOAD_COL + 9'(9'(step_rem) * 9'h003);
    end

endmodule : ofp_j1_locator
`default_nettype wire

// >>> verilog/ofp_pkg.sv
// constants shared by the outgoing frame pulse generator
package ofp_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // clock
    localparam int CLK_PERIOD_NS = 8;                  // 125 MHz system clock

    ////////////////////////////////////////////////////////////////////////////
    // frame geometry
    localparam logic [3:0] FRAME_ROWS = 4'h9;          // rows per transport frame
    localparam logic [10:0] STM1_COLS = 11'h10e;       // 270 byte columns, one stm-1
    localparam logic [10:0] STM4_COLS = 11'h438;       // 1080 byte columns, stm-4
    localparam logic [10:0] STM1_C1_COL = 11'h006;     // first c1 after 3 a1 + 3 a2
    localparam logic [10:0] STM4_C1_COL = 11'h018;     // first c1 after 12 a1 + 12 a2
    localparam logic [3:0] PAYLOAD_ROW = 4'h3;         // row holding the pointer bytes
    localparam logic [8:0] PAYLOAD_COL = 9'h009;       // first payload column of a row
    localparam logic [9:0] PTR_PER_ROW = 10'h057;      // 87 pointer steps per row
    localparam logic [9:0] PTR_RESET = 10'h000;        // pointer value after reset
    localparam int STREAMS = 4;                        // stm-1 streams inside an stm-4

    ////////////////////////////////////////////////////////////////////////////
    // timing counts
    localparam int V1_BYTES_AFTER_J1 = 3;              // v1 mark is third byte after j1
    localparam int STM4_INTERLEAVE = 4;                // stm-4 byte interleave factor
    localparam int V1_TAP_STM4 = V1_BYTES_AFTER_J1 * STM4_INTERLEAVE;
    localparam int BYPASS_DELAY = 2;                   // delay stages before the output flop

    ////////////////////////////////////////////////////////////////////////////
    // register map, byte offsets, one 32-bit word each
    localparam logic [5:0] REG_CTRL = 6'h00;           // enables, bypass, v1 marking
    localparam logic [5:0] REG_STATUS = 6'h04;         // frame position and mode
    localparam logic [5:0] REG_PTR_BASE = 6'h08;       // msb at base+8k, lsb at base+8k+4
    localparam logic [5:0] REG_PTR_LAST = 6'h24;       // last pointer register
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam int CTRL_TGE_POS = 0;                   // [3:0] tributary group enable
    localparam int CTRL_BYP_POS = 4;                   // [7:4] tributary group bypass
    localparam int CTRL_V1_POS = 8;                    // [11:8] first tributary mark enable
    localparam int STAT_ROW_POS = 0;                   // [3:0] row counter
    localparam int STAT_COL_POS = 4;                   // [14:4] column counter
    localparam int STAT_MODE_POS = 16;                 // [16] width select as sampled

    // bus handshake states
    typedef enum logic {
        OFP_BUS_IDLE,
        OFP_BUS_ANSWER
    } ofp_bus_state_t;

endpackage : ofp_pkg
